// ===== logic/utopia2_phy_cfg.svh
`ifndef UTOPIA2_PHY_CFG_SVH
`define UTOPIA2_PHY_CFG_SVH

// words in one cell on an 8-bit bus (53 octets) and a 16-bit bus (27 words)
`define CELL_WORDS_NARROW   8'd53
`define CELL_WORDS_WIDE     8'd27
// octet-level flow control: room flag deasserts at this many free word slots or fewer
`define OCTET_ROOM_LIMIT    4
// address that no port answers
`define NULL_PORT_ADDR      5'h1f
// default depth of the transmit cell store, in words
`define TX_STORE_DEPTH      128
// width of one bus word
`define BUS_WIDTH           16
`define ADDR_WIDTH          5

`endif

// ===== logic/utopia2_phy_pkg.sv
package utopia2_phy_pkg;

	// one bus word with its start-of-cell mark
	typedef struct packed {
		logic        start;
		logic [15:0] data;
	} cell_word_t;

	// every asynchronous pin, sampled together
	typedef struct packed {
		logic        tx_clk;
		logic        tx_en_n;
		logic        tx_start;
		logic        tx_par;
		logic [15:0] tx_data;
		logic [4:0]  tx_sel;
		logic        rx_clk;
		logic        rx_en_n;
		logic [4:0]  rx_sel;
		logic        cell_level;
		logic        wide;
		logic [4:0]  port_addr;
	} pin_sample_t;

endpackage : utopia2_phy_pkg

// ===== logic/cell_store.sv
`timescale 1ns/10ps

// simple dual-port word store, read data registered
module cell_store #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 128,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             rd_en_in,
	input  wire logic [AW-1:0]    rd_addr_in,
	output logic      [WIDTH-1:0] rd_data_out
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	// array has no reset, so it can map onto block ram
	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_out <= '0;
		end else if (rd_en_in) begin
			rd_data_out <= mem_reg[rd_addr_in];
		end
	end

endmodule : cell_store

// ===== logic/utopia2_phy_cell_port.sv
`timescale 1ns/10ps
`include "utopia2_phy_cfg.svh"
// What this block does
// - octet mode: room flag low means at most four more writes accepted.
// - cell mode: room flag driven only the cycle after our address.
// - when polled, room flag high if a whole cell fits, else low.
// - read enable low: data and start sampled at end of next cycle.
// - cell-mode polls and reads answer only our own address, never address 31; writes ignore the address.
// - odd parity over bits 7..0, or 15..0 on the wide bus.

module utopia2_phy_cell_port #(
	parameter int DEPTH = `TX_STORE_DEPTH,
	parameter int AW    = $clog2(DEPTH),
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic                      core_clk_in,
	input  wire logic                      rst_b_in,
	// link pins, all asynchronous to the core clock
	input  wire logic                      tx_byte_clock_in,
	input  wire logic                      tx_write_enable_n_in,
	input  wire logic                      tx_cell_start_in,
	input  wire logic                      tx_parity_bit_in,
	input  wire logic [15:0]               tx_cell_bus_in,
	input  wire logic [4:0]                tx_phy_select_in,
	output logic                           tx_cell_room_out,
	output logic                           tx_cell_room_oe_out,
	input  wire logic                      rx_byte_clock_in,
	input  wire logic                      rx_read_enable_n_in,
	input  wire logic [4:0]                rx_phy_select_in,
	output logic [15:0]                    rx_cell_bus_out,
	output logic                           rx_cell_bus_oe_out,
	output logic                           rx_cell_start_out,
	output logic                           rx_cell_start_oe_out,
	// straps
	input  wire logic                      cell_level_mode_in,
	input  wire logic                      wide_bus_in,
	input  wire logic [4:0]                port_addr_in,
	// core side: transmit words towards the framer
	output utopia2_phy_pkg::cell_word_t    tx_word_out,
	output logic                           tx_word_valid_out,
	input  wire logic                      tx_word_ready_in,
	output logic                           tx_parity_error_out,
	output logic                           tx_overflow_out,
	// core side: receive words from the framer
	input  utopia2_phy_pkg::cell_word_t    rx_word_in,
	input  wire logic                      rx_word_valid_in,
	output logic                           rx_word_take_out
);

	utopia2_phy_pkg::pin_sample_t pin_raw;
	utopia2_phy_pkg::pin_sample_t pin_meta_reg;
	utopia2_phy_pkg::pin_sample_t pin_reg;
	logic                         rst_meta_reg;
	logic                         rst_sync_reg;
	logic                         tx_clk_last_reg;
	logic                         rx_clk_last_reg;
	logic                         tx_edge;
	logic                         rx_edge;
	logic [CW-1:0]                count_reg;
	logic [CW-1:0]                count_next;
	logic [CW-1:0]                free_words;
	logic [AW-1:0]                wr_ptr_reg;
	logic [AW-1:0]                rd_ptr_reg;
	logic                         wr_en;
	logic                         rd_en;
	logic                         rd_pending_reg;
	logic [7:0]                   cell_words;
	logic                         parity_ok;
	logic                         addr_match_tx;
	logic                         addr_match_rx;
	logic                         rx_selected_reg;

	// reset released through two flops
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign pin_raw = '{
		tx_clk:     tx_byte_clock_in,
		tx_en_n:    tx_write_enable_n_in,
		tx_start:   tx_cell_start_in,
		tx_par:     tx_parity_bit_in,
		tx_data:    tx_cell_bus_in,
		tx_sel:     tx_phy_select_in,
		rx_clk:     rx_byte_clock_in,
		rx_en_n:    rx_read_enable_n_in,
		rx_sel:     rx_phy_select_in,
		cell_level: cell_level_mode_in,
		wide:       wide_bus_in,
		port_addr:  port_addr_in
	};

	// two-flop synchroniser; first stage feeds only the second
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pin_meta_reg <= '0;
			pin_reg      <= '0;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_reg      <= pin_meta_reg;
		end
	end

	// rising edges of the two link clocks
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			tx_clk_last_reg <= 1'b0;
			rx_clk_last_reg <= 1'b0;
		end else begin
			tx_clk_last_reg <= pin_reg.tx_clk;
			rx_clk_last_reg <= pin_reg.rx_clk;
		end
	end

	// data was synchronised alongside its clock, so both line up
	assign tx_edge = pin_reg.tx_clk & ~tx_clk_last_reg;
	assign rx_edge = pin_reg.rx_clk & ~rx_clk_last_reg;

	// own address matches; the null port is never ours
	assign addr_match_tx = (pin_reg.tx_sel == pin_reg.port_addr) &&
		(pin_reg.port_addr != `NULL_PORT_ADDR);
	assign addr_match_rx = (pin_reg.rx_sel == pin_reg.port_addr) &&
		(pin_reg.port_addr != `NULL_PORT_ADDR);

	// transmit side

	// odd parity: data bits plus parity bit must xor to one
	assign parity_ok = pin_reg.wide ?
		((^pin_reg.tx_data) ^ pin_reg.tx_par) :
		((^pin_reg.tx_data[7:0]) ^ pin_reg.tx_par);

	// write only on cycles the far side marks valid
	assign wr_en = tx_edge && !pin_reg.tx_en_n && (count_reg < CW'(DEPTH));
	assign rd_en = (count_reg != '0) && !rd_pending_reg &&
		(!tx_word_valid_out || tx_word_ready_in);

	assign count_next = CW'(count_reg + CW'(wr_en) - CW'(rd_en));
	assign free_words = CW'(CW'(DEPTH) - count_next);
	assign cell_words = pin_reg.wide ? `CELL_WORDS_WIDE : `CELL_WORDS_NARROW;

	// store occupancy and pointers
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			count_reg  <= '0;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			count_reg <= count_next;
			if (wr_en) begin
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			end
			if (rd_en) begin
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			end
		end
	end

	// start mark stored with its word, kept as the far side gave it
	cell_store #(
		.WIDTH ($bits(utopia2_phy_pkg::cell_word_t)),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_tx_store (
		.clk_in      (core_clk_in),
		.rst_b_in    (rst_sync_reg),
		.wr_en_in    (wr_en),
		.wr_addr_in  (wr_ptr_reg),
		.wr_data_in  ({pin_reg.tx_start, pin_reg.tx_data}),
		.rd_en_in    (rd_en),
		.rd_addr_in  (rd_ptr_reg),
		.rd_data_out (tx_word_out)
	);

	// read data lands one cycle after the read; valid follows it
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rd_pending_reg    <= 1'b0;
			tx_word_valid_out <= 1'b0;
		end else begin
			rd_pending_reg <= rd_en;
			if (rd_pending_reg) begin
				tx_word_valid_out <= 1'b1;
			end else if (tx_word_ready_in) begin
				tx_word_valid_out <= 1'b0;
			end
		end
	end

	// error pulses, one core cycle per bad write
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			tx_parity_error_out <= 1'b0;
			tx_overflow_out     <= 1'b0;
		end else begin
			tx_parity_error_out <= tx_edge && !pin_reg.tx_en_n && !parity_ok;
			tx_overflow_out     <= tx_edge && !pin_reg.tx_en_n &&
				(count_reg >= CW'(DEPTH));
		end
	end

	// room flag: octet mode follows free space every cycle;
	// cell mode is sampled at link edges only, as the poll is
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			tx_cell_room_out    <= 1'b1;
			tx_cell_room_oe_out <= 1'b0;
		end else if (!pin_reg.cell_level) begin
			tx_cell_room_oe_out <= 1'b1;
			tx_cell_room_out    <= (free_words > CW'(`OCTET_ROOM_LIMIT));
		end else if (tx_edge) begin
			tx_cell_room_oe_out <= addr_match_tx;
			tx_cell_room_out    <= addr_match_tx &&
				(free_words >= CW'(cell_words));
		end
	end

	// receive side

	// selection is taken while the enable is high, as in a poll
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rx_selected_reg <= 1'b0;
		end else if (rx_edge && pin_reg.rx_en_n) begin
			rx_selected_reg <= addr_match_rx;
		end
	end

	// drive in the link cycle after an enabled one; the far side
	// samples at its close, well after our update a few core clocks in
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rx_cell_bus_oe_out   <= 1'b0;
			rx_cell_start_oe_out <= 1'b0;
			rx_cell_bus_out      <= '0;
			rx_cell_start_out    <= 1'b0;
			rx_word_take_out     <= 1'b0;
		end else begin
			rx_word_take_out <= 1'b0;
			if (rx_edge) begin
				rx_cell_bus_oe_out   <= !pin_reg.rx_en_n && rx_selected_reg;
				rx_cell_start_oe_out <= !pin_reg.rx_en_n && rx_selected_reg;
				if (!pin_reg.rx_en_n && rx_selected_reg) begin
					rx_cell_bus_out   <= rx_word_valid_in ? rx_word_in.data : '0;
					rx_cell_start_out <= rx_word_valid_in && rx_word_in.start;
					rx_word_take_out  <= rx_word_valid_in;
				end
			end
		end
	end

endmodule : utopia2_phy_cell_port

// ===== sim/utopia2_phy_cell_port_assertions.sv
`timescale 1ns/10ps
module utopia2_phy_checker (
	input wire logic       core_clk_in,
	input wire logic       rst_b_in,
	input wire logic       cell_level_mode_in,
	input wire logic [4:0] tx_phy_select_in,
	input wire logic [4:0] port_addr_in,
	input wire logic       rx_read_enable_n_in,
	input wire logic       tx_cell_room_oe_out,
	input wire logic       rx_cell_bus_oe_out,
	input wire logic       rx_cell_start_oe_out,
	input wire logic       tx_parity_error_out,
	input wire logic       rx_word_take_out
);
	logic [3:0] mode_age_reg, sel_age_reg, en_age_reg;
	logic       mode_last_reg;
	function automatic logic [3:0] bump(input logic [3:0] a, input logic clr);
		return clr ? 4'h0 : a + {3'h0, a != 4'hf};
	endfunction : bump
	// saturating ages; straps pass sync flops, so only settled modes are judged
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode_last_reg <= 1'b0;
			mode_age_reg  <= 4'h0;
			sel_age_reg   <= 4'hf;
			en_age_reg    <= 4'hf;
		end else begin
			mode_last_reg <= cell_level_mode_in;
			mode_age_reg  <= bump(mode_age_reg, mode_last_reg != cell_level_mode_in);
			sel_age_reg   <= bump(sel_age_reg, tx_phy_select_in == port_addr_in);
			en_age_reg    <= bump(en_age_reg, !rx_read_enable_n_in);
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	AST_RX_OE_PAIR: assert property (rx_cell_bus_oe_out == rx_cell_start_oe_out)
		else $error("receive enables differ");
	AST_RX_OE_CAUSE: assert property ($rose(rx_cell_bus_oe_out) |-> en_age_reg < 4'h6)
		else $error("receive drive without enable");
	AST_RX_OE_FALL: assert property ($fell(rx_cell_bus_oe_out) |-> rx_read_enable_n_in)
		else $error("receive drive dropped while enabled");
	AST_TAKE_OE: assert property (rx_word_take_out |-> ##[0:2] rx_cell_bus_oe_out)
		else $error("word taken but not driven");
	AST_PAR_PULSE: assert property (tx_parity_error_out |=> !tx_parity_error_out)
		else $error("parity error pulse too long");
	AST_OCTET_OE: assert property (!cell_level_mode_in && mode_age_reg == 4'hf |-> tx_cell_room_oe_out)
		else $error("octet room flag not driven");
	AST_CELL_OE_WIN: assert property ($rose(tx_cell_room_oe_out) && cell_level_mode_in && mode_age_reg == 4'hf |-> sel_age_reg < 4'h9)
		else $error("room flag driven without own poll");
	AST_CELL_OE_STAND: assert property ($rose(tx_cell_room_oe_out) && cell_level_mode_in && mode_age_reg == 4'hf |=> tx_cell_room_oe_out [*4])
		else $error("room flag drive too short");
endmodule : utopia2_phy_checker
bind utopia2_phy_cell_port utopia2_phy_checker chk (.*);

// ===== sim/atm_layer_model.sv
`timescale 1ns/10ps
module atm_layer_model (
	input  wire logic        core_clk_in,
	input  wire logic        wide_in,
	input  wire logic [15:0] rx_bus_in,
	input  wire logic        rx_start_in,
	input  wire logic        rx_oe_in,
	output logic             tx_clk_out,
	output logic             tx_en_n_out,
	output logic             tx_start_out,
	output logic             tx_par_out,
	output logic [15:0]      tx_data_out,
	output logic [4:0]       tx_sel_out,
	output logic [4:0]       rx_sel_out,
	output logic             rx_clk_out,
	output logic             rx_en_n_out,
	output logic [16:0]      rx_seen_out
);
	logic [16:0] last = 17'h0;
	// all lines idle at time zero, enables high
	initial begin
		{tx_clk_out, rx_clk_out, tx_start_out, tx_par_out, tx_en_n_out, rx_en_n_out} = 6'h3;
		tx_data_out = 16'h0;
		{tx_sel_out, rx_sel_out} = 10'h3ff;
		rx_seen_out = 17'h0;
	end
	// one link cycle; the clock stands low between calls
	task automatic cyc(input bit rx);
		repeat (5) @(negedge core_clk_in);
		// a released bus reads back as the inverse of its last value
		rx_seen_out = rx_oe_in ? {rx_start_in, rx_bus_in} : ~last;
		last = rx_seen_out;
		rx_clk_out = rx;
		tx_clk_out = !rx;
		repeat (5) @(negedge core_clk_in);
		{rx_clk_out, tx_clk_out} = 2'h0;
	endtask : cyc
	// one written word; start mark only on a first word
	task automatic twr(input logic [15:0] d, input bit sop, input bit bad);
		tx_data_out = d;
		tx_start_out = sop;
		tx_par_out = ~^(wide_in ? d : {8'h0, d[7:0]}) ^ bad; // odd parity
		tx_en_n_out = 1'b0;
		cyc(1'b0);
		tx_en_n_out = 1'b1;
		tx_start_out = 1'b0;
		tx_data_out = ~d;
		// idle core cycle so back-to-back calls never drive a line twice at once
		@(negedge core_clk_in);
	endtask : twr
	// select, enable, then sample at the following edge
	task automatic rrd(input logic [4:0] a);
		rx_sel_out = a;
		cyc(1'b1);
		rx_en_n_out = 1'b0;
		cyc(1'b1);
		rx_en_n_out = 1'b1;
		rx_sel_out = 5'h1f;
		cyc(1'b1);
	endtask : rrd
endmodule : atm_layer_model

// ===== sim/utopia2_phy_cell_port_bench.sv
`timescale 1ns/10ps
`include "utopia2_phy_cfg.svh"
module utopia2_phy_cell_port_bench;
	localparam int DEPTH = 64; // small store keeps fills short
	logic core_clk_in = 1'b0, rst_b_in = 1'b0, cell_level_mode_in = 1'b0, wide_bus_in = 1'b0;
	logic tx_word_ready_in = 1'b1, rx_word_valid_in = 1'b0;
	logic [4:0] port_addr_in = 5'h05;
	utopia2_phy_pkg::cell_word_t rx_word_in = '0, tx_word_out, last_word;
	logic tx_byte_clock_in, tx_write_enable_n_in, tx_cell_start_in, tx_parity_bit_in;
	logic rx_byte_clock_in, rx_read_enable_n_in, tx_cell_room_out, tx_cell_room_oe_out;
	logic [15:0] tx_cell_bus_in, rx_cell_bus_out;
	logic [4:0] tx_phy_select_in, rx_phy_select_in;
	logic rx_cell_bus_oe_out, rx_cell_start_out, rx_cell_start_oe_out, tx_word_valid_out;
	logic tx_parity_error_out, tx_overflow_out, rx_word_take_out;
	logic [16:0] rx_seen;
	int err_count = 0, checks_done = 0, npar = 0, novf = 0, ntake = 0, kfill = 0;
	utopia2_phy_cell_port #(.DEPTH(DEPTH)) DUT (.*);
	atm_layer_model atm (.core_clk_in(core_clk_in), .wide_in(wide_bus_in),
		.rx_bus_in(rx_cell_bus_out), .rx_start_in(rx_cell_start_out),
		.rx_oe_in(rx_cell_bus_oe_out), .tx_clk_out(tx_byte_clock_in),
		.tx_en_n_out(tx_write_enable_n_in), .tx_start_out(tx_cell_start_in),
		.tx_par_out(tx_parity_bit_in), .tx_data_out(tx_cell_bus_in),
		.tx_sel_out(tx_phy_select_in), .rx_sel_out(rx_phy_select_in),
		.rx_clk_out(rx_byte_clock_in), .rx_en_n_out(rx_read_enable_n_in),
		.rx_seen_out(rx_seen));
	always #4 core_clk_in = ~core_clk_in;
	// pulse tallies and the last word the framer took
	always @(posedge core_clk_in) begin
		npar <= npar + (tx_parity_error_out === 1'b1);
		novf <= novf + (tx_overflow_out === 1'b1);
		ntake <= ntake + (rx_word_take_out === 1'b1);
		if (tx_word_valid_out && tx_word_ready_in)
			last_word <= tx_word_out;
	end
	task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic settle;
		repeat (8) @(negedge core_clk_in);
	endtask : settle
	// drain until valid stays low; bounded so a stuck valid ends the run
	task automatic drain;
		int n, q;
		tx_word_ready_in = 1'b1;
		for (n = 0, q = 0; q < 4 && n < 2000; n++) begin
			@(negedge core_clk_in);
			q = tx_word_valid_out === 1'b0 ? q + 1 : 0;
		end
		if (q < 4) begin
			err_count++;
			$display("Error at %0t: framer drain timed out", $time);
			end_of_test();
		end
	endtask : drain
	// per width: bad-parity word kept unmarked, upper lane ignored when narrow, bad parity flagged
	task automatic t_parity;
		int p;
		logic [15:0] m;
		for (int w = 0; w < 2; w++) begin
			wide_bus_in = w[0];
			m = w ? 16'hffff : 16'h00ff;
			settle();
			p = npar;
			atm.twr(16'h8a31, 1'b1, 1'b0);
			atm.twr(16'h0100, 1'b0, 1'b0);
			settle();
			chk(17'(npar - p), 17'h0);
			atm.twr(16'h0003, 1'b0, 1'b1);
			settle();
			chk(17'(npar - p), 17'h1);
			chk({last_word.start, last_word.data & m}, {1'b0, 16'h0003 & m});
		end
	endtask : t_parity
	// stalled fill: once the flag drops, four more writes fit and the fifth is lost
	task automatic t_octet;
		int o;
		tx_word_ready_in = 1'b0;
		do begin
			atm.twr(16'h1234, kfill == 0, 1'b0);
			settle();
			kfill++;
		end while (tx_cell_room_out !== 1'b0 && kfill < DEPTH + 2);
		chk(kfill == DEPTH - 4 || kfill == DEPTH - 3, 1);
		o = novf;
		repeat (4) atm.twr(16'h1234, 1'b0, 1'b0);
		settle();
		chk(17'(novf - o), 17'h0);
		atm.twr(16'h1234, 1'b0, 1'b0);
		settle();
		chk(17'(novf - o), 17'h1);
		drain();
		chk(tx_cell_room_out, 1'b1);
	endtask : t_octet
	// null strap never answers; polls of own, null and foreign address, then fill
	// until a cell no longer fits (first word waits in the framer register)
	task automatic t_cell;
		logic [4:0] a [3] = '{5'h05, 5'h1f, 5'h06};
		int k;
		cell_level_mode_in = 1'b1;
		wide_bus_in = 1'b0;
		port_addr_in = 5'h1f;
		atm.tx_sel_out = 5'h1f;
		settle();
		atm.cyc(1'b0);
		settle();
		chk(tx_cell_room_oe_out, 1'b0);
		port_addr_in = 5'h05;
		for (int i = 0; i < 3; i++) begin
			atm.tx_sel_out = a[i];
			atm.cyc(1'b0);
			settle();
			chk({tx_cell_room_oe_out, tx_cell_room_out & (i == 0)}, {i == 0, i == 0});
		end
		atm.tx_sel_out = port_addr_in;
		tx_word_ready_in = 1'b0;
		atm.cyc(1'b0);
		for (k = 0; tx_cell_room_out === 1'b1 && k < DEPTH; k++)
			atm.twr(16'h00aa, k == 0, 1'b0);
		chk(tx_cell_room_oe_out, 1'b1);
		chk(17'(k), 17'(DEPTH + 2 - `CELL_WORDS_NARROW));
		drain();
	endtask : t_cell
	// own address reads marked then plain word; the null address leaves the bus released
	task automatic t_rx;
		int t;
		wide_bus_in = 1'b1;
		rx_word_in = '{start: 1'b1, data: 16'hc35a};
		rx_word_valid_in = 1'b1;
		settle();
		t = ntake;
		atm.rrd(port_addr_in);
		chk(rx_seen, {1'b1, 16'hc35a});
		rx_word_in = '{start: 1'b0, data: 16'h0f0f};
		atm.rrd(port_addr_in);
		chk(rx_seen, {1'b0, 16'h0f0f});
		atm.rrd(5'h1f);
		chk(rx_seen, {1'b1, 16'hf0f0});
		chk(17'(ntake - t), 17'h2);
	endtask : t_rx
	initial begin
		repeat (16) @(negedge core_clk_in);
		chk({tx_cell_room_out, tx_cell_room_oe_out, rx_cell_bus_oe_out, tx_word_valid_out},
			4'h8);
		rst_b_in = 1'b1;
		settle();
		t_parity();
		t_octet();
		t_cell();
		t_rx();
		end_of_test();
	end
endmodule : utopia2_phy_cell_port_bench
